// File: verilog/rail_bank_regs.svh
// Register offsets, field positions, write masks and reset values
// Assumes an 8-bit register index on the internal control port
`ifndef RAIL_BANK_REGS_SVH
`define RAIL_BANK_REGS_SVH
`define BUCK4_CONTROL_ADDR 8'hbd
`define BUCK4_SEQUENCING_ADDR 8'hbe
`define BUCK4_LOW_POWER_ADDR 8'hbf
`define BOOST5_CONTROL_ADDR 8'hc0
`define BOOST5_SEQUENCING_ADDR 8'hc1
`define BUCK6_CONTROL_ADDR 8'hc3
`define BUCK6_SEQUENCING_ADDR 8'hc4
`define BUCK6_LOW_POWER_ADDR 8'hc5
`define SWITCH_CONTROL_ADDR 8'hc7
// Writable bits; the rest read as zero
`define BUCK_CONTROL_MASK 16'h0c7f
`define BUCK6_CONTROL_MASK 16'hcc7f
`define SEQUENCING_MASK 16'hffc0
`define LOW_POWER_MASK 16'h737f
`define BOOST5_CONTROL_MASK 16'h535b
`define SWITCH_CONTROL_MASK 16'hffd3
// Mask-programmed defaults
`define BUCK4_CONTROL_RST 16'h0000
`define SEQUENCING_RST 16'h0000
`define LOW_POWER_RST 16'h0006
`define BOOST5_CONTROL_RST 16'h0008
`define BUCK6_CONTROL_RST 16'h0000
`define SWITCH_CONTROL_RST 16'h0003
// Field positions
`define FAULT_ACT_HI 15
`define FAULT_ACT_LO 14
`define START_SLOT_HI 13
`define START_SLOT_LO 10
`define STOP_SLOT_HI 9
`define STOP_SLOT_LO 6
`define SLEEP_MODE_HI 14
`define SLEEP_MODE_LO 12
`define SLEEP_SRC_HI 9
`define SLEEP_SRC_LO 8
`define OUTPUT_FLOAT_BIT 10
`define BOOST5_SLEEP_BIT 12
`define RAMP_HIGH_BIT 4
`define RAMP_LOW_BIT 3
`define SWITCH_SLEEP_BIT 4
// Slot codes
`define SLOT_NONE 4'h0
`define SLOT_FIRST 4'h1
`define SLOT_LAST 4'he
`define SLOT_EDGE 4'hf
`endif

// File: verilog/rail_bank_pkg.sv
// Types shared by the rail sequencing bank
// Assumes nothing beyond the register header
package rail_bank_pkg;
	typedef enum logic [1:0]
	{
		SEQ_OFF = 2'b00,
		SEQ_UP = 2'b01,
		SEQ_ACTIVE = 2'b11,
		SEQ_DOWN = 2'b10
	} seq_state_t;
	typedef struct packed
	{
		logic enable;
		logic discharge;
		logic standby;
		logic ldo_mode;
		logic [6:0] voltage;
	} buck_drive_t;
	typedef struct packed
	{
		logic enable;
		logic discharge;
		logic [1:0] feedback;
		logic [1:0] ramp;
	} boost_drive_t;
endpackage

// File: verilog/rail_sequencing_bank.sv
// Control bank and slot sequencer for bucks 4 and 6, boost 5, limit switch
// Assumes a serial interface decoder drives the register port
`timescale 1ns/10ps
`include "rail_bank_regs.svh"

module rail_sequencing_bank
#(
	parameter logic [6:0] BUCK4_VOLT_RST = 7'h00,
	parameter logic [6:0] BUCK6_VOLT_RST = 7'h00,
	parameter logic [3:0] BUCK4_START_RST = 4'h0,
	parameter logic [3:0] BUCK6_START_RST = 4'h0
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Register port from the serial interface
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	// Power state machine
	input wire logic defaults_reload,
	input wire logic power_up_req,
	input wire logic power_down_req,
	input wire logic slot_tick,
	output rail_bank_pkg::seq_state_t seq_state,
	output logic [3:0] seq_slot,
	// Hibernate sources
	input wire logic sw_hibernate,
	input wire logic low_power_input_one,
	input wire logic low_power_input_two,
	input wire logic low_power_input_three,
	input wire logic gpio_hibernate,
	// Faults: bit 0 buck4, 1 boost5, 2 buck6, 3 switch over-current
	input wire logic [3:0] fault,
	output logic fault_irq,
	output logic system_shutdown,
	// Rail drives
	output rail_bank_pkg::buck_drive_t buck4_drive,
	output rail_bank_pkg::buck_drive_t buck6_drive,
	output rail_bank_pkg::boost_drive_t boost5_drive,
	output logic [1:0] buck6_capacitor_setting,
	output logic switch_enable
);
	import rail_bank_pkg::*;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	logic [15:0] buck4_control, buck4_sequencing, buck4_low_power;
	logic [15:0] boost5_control, boost5_sequencing;
	logic [15:0] buck6_control, buck6_sequencing, buck6_low_power;
	logic [15:0] current_switch_control;
	logic [15:0] next_buck4_control, next_buck4_sequencing, next_buck4_low_power;
	logic [15:0] next_boost5_control, next_boost5_sequencing;
	logic [15:0] next_buck6_control, next_buck6_sequencing, next_buck6_low_power;
	logic [15:0] next_current_switch_control;
	logic [15:0] next_reg_rdata;

	logic [15:0] seq_reg [4];
	logic [3:0] rail_on;
	logic [3:0] next_rail_on;
	seq_state_t next_seq_state;
	logic [3:0] next_seq_slot;
	logic next_fault_irq, next_system_shutdown;
	logic [3:0] sleep;
	logic [1:0] act [4];

	assign seq_reg[0] = buck4_sequencing;
	assign seq_reg[1] = boost5_sequencing;
	assign seq_reg[2] = buck6_sequencing;
	assign seq_reg[3] = current_switch_control;

	// Register writes and reads
	always_comb
	begin
		next_buck4_control = buck4_control;
		next_buck4_sequencing = buck4_sequencing;
		next_buck4_low_power = buck4_low_power;
		next_boost5_control = boost5_control;
		next_boost5_sequencing = boost5_sequencing;
		next_buck6_control = buck6_control;
		next_buck6_sequencing = buck6_sequencing;
		next_buck6_low_power = buck6_low_power;
		next_current_switch_control = current_switch_control;
		next_reg_rdata = reg_rdata;
		if (defaults_reload)
		begin
			next_buck4_control = `BUCK4_CONTROL_RST | {9'h000, BUCK4_VOLT_RST};
			next_buck4_sequencing = `SEQUENCING_RST | {2'h0, BUCK4_START_RST, 10'h000};
			next_buck4_low_power = `LOW_POWER_RST;
			next_boost5_control = `BOOST5_CONTROL_RST;
			next_boost5_sequencing = `SEQUENCING_RST;
			next_buck6_control = `BUCK6_CONTROL_RST | {9'h000, BUCK6_VOLT_RST};
			next_buck6_sequencing = `SEQUENCING_RST | {2'h0, BUCK6_START_RST, 10'h000};
			next_buck6_low_power = `LOW_POWER_RST;
			next_current_switch_control = `SWITCH_CONTROL_RST;
		end
		else if (reg_write)
		begin
			unique case (reg_addr)
				`BUCK4_CONTROL_ADDR: next_buck4_control = reg_wdata & `BUCK_CONTROL_MASK;
				`BUCK4_SEQUENCING_ADDR: next_buck4_sequencing = reg_wdata & `SEQUENCING_MASK;
				`BUCK4_LOW_POWER_ADDR: next_buck4_low_power = reg_wdata & `LOW_POWER_MASK;
				`BOOST5_CONTROL_ADDR: next_boost5_control = reg_wdata & `BOOST5_CONTROL_MASK;
				`BOOST5_SEQUENCING_ADDR: next_boost5_sequencing = reg_wdata & `SEQUENCING_MASK;
				`BUCK6_CONTROL_ADDR:
				begin
					next_buck6_control = reg_wdata & `BUCK6_CONTROL_MASK;
					// Unused capacitor code would misprogram the loop, so keep the old one
					if (reg_wdata[15:14] == 2'b10)
						next_buck6_control[15:14] = buck6_control[15:14];
				end
				`BUCK6_SEQUENCING_ADDR: next_buck6_sequencing = reg_wdata & `SEQUENCING_MASK;
				`BUCK6_LOW_POWER_ADDR: next_buck6_low_power = reg_wdata & `LOW_POWER_MASK;
				`SWITCH_CONTROL_ADDR: next_current_switch_control = reg_wdata & `SWITCH_CONTROL_MASK;
				default: next_buck4_control = buck4_control;
			endcase
		end
		if (reg_read)
		begin
			unique case (reg_addr)
				`BUCK4_CONTROL_ADDR: next_reg_rdata = buck4_control;
				`BUCK4_SEQUENCING_ADDR: next_reg_rdata = buck4_sequencing;
				`BUCK4_LOW_POWER_ADDR: next_reg_rdata = buck4_low_power;
				`BOOST5_CONTROL_ADDR: next_reg_rdata = boost5_control;
				`BOOST5_SEQUENCING_ADDR: next_reg_rdata = boost5_sequencing;
				`BUCK6_CONTROL_ADDR: next_reg_rdata = buck6_control;
				`BUCK6_SEQUENCING_ADDR: next_reg_rdata = buck6_sequencing;
				`BUCK6_LOW_POWER_ADDR: next_reg_rdata = buck6_low_power;
				`SWITCH_CONTROL_ADDR: next_reg_rdata = current_switch_control;
				default: next_reg_rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			buck4_control <= `BUCK4_CONTROL_RST | {9'h000, BUCK4_VOLT_RST};
			buck4_sequencing <= `SEQUENCING_RST | {2'h0, BUCK4_START_RST, 10'h000};
			buck4_low_power <= `LOW_POWER_RST;
			boost5_control <= `BOOST5_CONTROL_RST;
			boost5_sequencing <= `SEQUENCING_RST;
			buck6_control <= `BUCK6_CONTROL_RST | {9'h000, BUCK6_VOLT_RST};
			buck6_sequencing <= `SEQUENCING_RST | {2'h0, BUCK6_START_RST, 10'h000};
			buck6_low_power <= `LOW_POWER_RST;
			current_switch_control <= `SWITCH_CONTROL_RST;
			reg_rdata <= 16'h0000;
		end
		else
		begin
			buck4_control <= next_buck4_control;
			buck4_sequencing <= next_buck4_sequencing;
			buck4_low_power <= next_buck4_low_power;
			boost5_control <= next_boost5_control;
			boost5_sequencing <= next_boost5_sequencing;
			buck6_control <= next_buck6_control;
			buck6_sequencing <= next_buck6_sequencing;
			buck6_low_power <= next_buck6_low_power;
			current_switch_control <= next_current_switch_control;
			reg_rdata <= next_reg_rdata;
		end
	end

	// Hibernate source selection
	function automatic logic pick_sleep(input logic [1:0] src);
		logic [3:0] req;
		req = {low_power_input_three, low_power_input_two, low_power_input_one, sw_hibernate};
		return req[src] | gpio_hibernate;
	endfunction

	// The function reads ports directly, so only always_comb tracks their changes
	always_comb
	begin
		sleep[0] = pick_sleep(buck4_low_power[`SLEEP_SRC_HI:`SLEEP_SRC_LO]);
		sleep[1] = pick_sleep(boost5_control[`SLEEP_SRC_HI:`SLEEP_SRC_LO]);
		sleep[2] = pick_sleep(buck6_low_power[`SLEEP_SRC_HI:`SLEEP_SRC_LO]);
		sleep[3] = sw_hibernate | gpio_hibernate;
	end

	// Buck drive from enable, sleep behaviour and image voltage
	function automatic buck_drive_t buck_drive(input logic on, input logic slp,
		input logic [15:0] ctl, input logic [15:0] lp);
		buck_drive_t d;
		logic [2:0] m;
		m = slp ? lp[`SLEEP_MODE_HI:`SLEEP_MODE_LO] : 3'h0;
		d.enable = on & (m != 3'h7);
		d.standby = (m == 3'h2) | (m == 3'h3);
		d.ldo_mode = (m == 3'h4) | (m == 3'h5);
		// Reserved code 110 behaves as no change
		d.voltage = (m == 3'h1 || m == 3'h3 || m == 3'h5) ? lp[6:0] : ctl[6:0];
		d.discharge = !d.enable & !ctl[`OUTPUT_FLOAT_BIT];
		return d;
	endfunction

	always_comb
	begin
		buck4_drive = buck_drive(rail_on[0], sleep[0], buck4_control, buck4_low_power);
		buck6_drive = buck_drive(rail_on[2], sleep[2], buck6_control, buck6_low_power);
		boost5_drive.enable = rail_on[1] & !(sleep[1] & boost5_control[`BOOST5_SLEEP_BIT]);
		boost5_drive.discharge = 1'b0;
		boost5_drive.feedback = boost5_control[1:0];
		boost5_drive.ramp = (boost5_control[1:0] == 2'b11) ? 2'b11 :
			{boost5_control[`RAMP_HIGH_BIT], boost5_control[`RAMP_LOW_BIT]};
		switch_enable = rail_on[3] & !(sleep[3] & !current_switch_control[`SWITCH_SLEEP_BIT]);
		buck6_capacitor_setting = buck6_control[15:14];
	end

	// Slot sequencer and fault actions
	always_comb
	begin
		logic [3:0] st, sp;
		logic sys;
		st = 4'h0;
		sp = 4'h0;
		sys = 1'b0;
		next_seq_state = seq_state;
		next_seq_slot = seq_slot;
		next_rail_on = rail_on;
		for (int i = 0; i < 4; i++)
		begin
			act[i] = seq_reg[i][`FAULT_ACT_HI:`FAULT_ACT_LO];
			st = seq_reg[i][`START_SLOT_HI:`START_SLOT_LO];
			sp = seq_reg[i][`STOP_SLOT_HI:`STOP_SLOT_LO];
			if (seq_state == SEQ_UP && slot_tick)
			begin
				if (st == seq_slot)
					next_rail_on[i] = 1'b1;
				if (seq_slot == `SLOT_LAST && st == `SLOT_EDGE)
					next_rail_on[i] = 1'b1;
			end
			if (seq_state == SEQ_DOWN && slot_tick)
			begin
				if (sp == seq_slot)
					next_rail_on[i] = 1'b0;
				if (seq_slot == `SLOT_LAST)
					next_rail_on[i] = 1'b0;
			end
			if (fault[i] && act[i] == 2'b01)
				next_rail_on[i] = 1'b0;
			if (fault[i] && act[i][1])
				sys = 1'b1;
		end
		unique case (seq_state)
			SEQ_OFF:
				if (power_up_req && !sys)
				begin
					next_seq_state = SEQ_UP;
					next_seq_slot = `SLOT_FIRST;
				end
			SEQ_UP:
				if (slot_tick)
				begin
					if (seq_slot == `SLOT_LAST)
						next_seq_state = SEQ_ACTIVE;
					else
						next_seq_slot = seq_slot + 4'h1;
				end
			SEQ_ACTIVE:
				if (power_down_req)
				begin
					next_seq_state = SEQ_DOWN;
					next_seq_slot = `SLOT_FIRST;
				end
			SEQ_DOWN:
				if (slot_tick)
				begin
					if (seq_slot == `SLOT_LAST)
					begin
						next_seq_state = SEQ_OFF;
						next_seq_slot = `SLOT_NONE;
					end
					else
						next_seq_slot = seq_slot + 4'h1;
				end
		endcase
		// A system fault aborts power-up or active and walks the shutdown slots
		if (sys && (seq_state == SEQ_UP || seq_state == SEQ_ACTIVE))
		begin
			next_seq_state = SEQ_DOWN;
			next_seq_slot = `SLOT_FIRST;
		end
		next_fault_irq = |fault;
		next_system_shutdown = sys;
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			seq_state <= SEQ_OFF;
			seq_slot <= `SLOT_NONE;
			rail_on <= 4'h0;
			fault_irq <= 1'b0;
			system_shutdown <= 1'b0;
		end
		else
		begin
			seq_state <= next_seq_state;
			seq_slot <= next_seq_slot;
			rail_on <= next_rail_on;
			fault_irq <= next_fault_irq;
			system_shutdown <= next_system_shutdown;
		end
	end

	sequence s_last_up_tick;
		seq_state == SEQ_UP && seq_slot == `SLOT_LAST && slot_tick && !(|fault);
	endsequence
	AST_FAULT_IRQ: assert property (|fault |=> fault_irq)
		else $error("fault did not raise interrupt");
	AST_CONVERTER_STOP: assert property (fault[0] && buck4_sequencing[15:14] == 2'b01
		|=> !rail_on[0])
		else $error("buck4 not stopped on fault");
	AST_UP_TO_ACTIVE: assert property (s_last_up_tick |=> seq_state == SEQ_ACTIVE)
		else $error("power-up did not reach active");
	AST_SLOT_STEP: assert property (seq_state == SEQ_UP && slot_tick && seq_slot != `SLOT_LAST
		&& !(|fault) |=> seq_slot == $past(seq_slot) + 4'h1)
		else $error("slot did not advance by one");
	AST_OFF_ALL_DOWN: assert property (seq_state == SEQ_DOWN && seq_slot == `SLOT_LAST
		&& slot_tick |=> rail_on == 4'h0 && seq_state == SEQ_OFF)
		else $error("rails left on after shutdown");
	AST_DISCHARGE: assert property (!buck4_drive.enable && !buck4_control[10]
		|-> buck4_drive.discharge)
		else $error("disabled buck4 not discharged");
	AST_IMAGE: assert property (sleep[0] && buck4_low_power[14:12] == 3'h1
		|-> buck4_drive.voltage == buck4_low_power[6:0])
		else $error("image voltage not applied");
	AST_GPIO_SLEEP: assert property (gpio_hibernate && buck6_low_power[14:12] == 3'h7
		|-> !buck6_drive.enable)
		else $error("gpio hibernate ignored");
	AST_RAMP_FORCE: assert property (boost5_control[1:0] == 2'b11
		|-> boost5_drive.ramp == 2'b11)
		else $error("ramp not forced");
	AST_RELOAD: assert property (defaults_reload |=> buck4_low_power == `LOW_POWER_RST
		&& current_switch_control == `SWITCH_CONTROL_RST)
		else $error("defaults not restored");
	AST_SWITCH_SLEEP: assert property (sw_hibernate && !current_switch_control[4]
		|-> !switch_enable)
		else $error("switch kept on in hibernate");
endmodule

// File: bench/host_model.sv
// Host side of the register port: write and read cycles on demand
// Assumes the bench calls wr and rd and that inputs change at falling edges
`timescale 1ns/10ps
module host_model
(
	// Clock
	input wire logic clk,
	// Register port
	output logic reg_write,
	output logic reg_read,
	output logic [7:0] reg_addr,
	output logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata
);
	initial
	begin
		reg_write = 1'b0;
		reg_read = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 16'h0000;
	end

	// Strobe lasts one full cycle so exactly one rising edge takes it
	task wr(input logic [7:0] a, input logic [15:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_write = 1'b1;
		@(negedge clk);
		reg_write = 1'b0;
		reg_wdata = ~d;
	endtask

	// Data is registered at the taking edge, so it is settled by the next falling edge
	task rd(input logic [7:0] a, output logic [15:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_read = 1'b1;
		@(negedge clk);
		reg_read = 1'b0;
		d = reg_rdata;
	endtask
endmodule

// File: bench/tb_top.sv
// Self-checking bench for the rail sequencing bank
// Assumes the host model drives the register port; bench drives the rest
`timescale 1ns/10ps
`include "rail_bank_regs.svh"
module tb_top;
	import rail_bank_pkg::*;
	logic clk = 1'b0;
	logic reset_n, defaults_reload, power_up_req, power_down_req, slot_tick;
	logic sw_hibernate, low_power_input_one, low_power_input_two, low_power_input_three;
	logic gpio_hibernate, reg_write, reg_read, fault_irq, system_shutdown, switch_enable;
	logic [3:0] fault, seq_slot;
	logic [7:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata;
	logic [1:0] buck6_capacitor_setting;
	seq_state_t seq_state;
	buck_drive_t buck4_drive, buck6_drive;
	boost_drive_t boost5_drive;
	int n_errors = 0;
	int n_checks = 0;
	int cycles = 0;
	int i;
	logic [7:0] adr [9] = '{`BUCK4_CONTROL_ADDR, `BUCK4_SEQUENCING_ADDR, `BUCK4_LOW_POWER_ADDR,
		`BOOST5_CONTROL_ADDR, `BOOST5_SEQUENCING_ADDR, `BUCK6_CONTROL_ADDR,
		`BUCK6_SEQUENCING_ADDR, `BUCK6_LOW_POWER_ADDR, `SWITCH_CONTROL_ADDR};
	logic [15:0] rst [9] = '{`BUCK4_CONTROL_RST, `SEQUENCING_RST, `LOW_POWER_RST,
		`BOOST5_CONTROL_RST, `SEQUENCING_RST, `BUCK6_CONTROL_RST, `SEQUENCING_RST,
		`LOW_POWER_RST, `SWITCH_CONTROL_RST};
	logic [15:0] msk [9] = '{`BUCK_CONTROL_MASK, `SEQUENCING_MASK, `LOW_POWER_MASK,
		`BOOST5_CONTROL_MASK, `SEQUENCING_MASK, `BUCK6_CONTROL_MASK, `SEQUENCING_MASK,
		`LOW_POWER_MASK, `SWITCH_CONTROL_MASK};

	always #5 clk = ~clk;

	host_model i_host_model (.clk(clk), .reg_write(reg_write), .reg_read(reg_read),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

	rail_sequencing_bank i_rail_sequencing_bank (.clk(clk), .reset_n(reset_n),
		.reg_write(reg_write), .reg_read(reg_read), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .defaults_reload(defaults_reload),
		.power_up_req(power_up_req), .power_down_req(power_down_req), .slot_tick(slot_tick),
		.seq_state(seq_state), .seq_slot(seq_slot), .sw_hibernate(sw_hibernate),
		.low_power_input_one(low_power_input_one), .low_power_input_two(low_power_input_two),
		.low_power_input_three(low_power_input_three), .gpio_hibernate(gpio_hibernate),
		.fault(fault), .fault_irq(fault_irq), .system_shutdown(system_shutdown),
		.buck4_drive(buck4_drive), .buck6_drive(buck6_drive), .boost5_drive(boost5_drive),
		.buck6_capacitor_setting(buck6_capacitor_setting), .switch_enable(switch_enable));

	task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task rdchk(input logic [7:0] a, input logic [15:0] e);
		logic [15:0] v;
		i_host_model.rd(a, v);
		check($sformatf("register %h", a), v, e);
	endtask

	task tick;
		@(negedge clk);
		slot_tick = 1'b1;
		@(negedge clk);
		slot_tick = 1'b0;
	endtask

	task close_out;
		$display("Checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Whole run needs well under a thousand cycles
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			n_errors++;
			close_out();
		end
	end

	initial
	begin
		{reset_n, defaults_reload, power_up_req, power_down_req, slot_tick} = '0;
		{sw_hibernate, low_power_input_one, low_power_input_two, low_power_input_three} = '0;
		gpio_hibernate = 1'b0;
		fault = 4'h0;
		repeat (5) @(negedge clk);
		reset_n = 1'b1;
		for (i = 0; i < 9; i++)
			rdchk(adr[i], rst[i]);
		rdchk(8'hc2, 16'h0000);
		for (i = 0; i < 9; i++)
		begin
			i_host_model.wr(adr[i], 16'hffff);
			rdchk(adr[i], msk[i]);
		end
		// Unused capacitor code must not replace the stored one
		i_host_model.wr(`BUCK6_CONTROL_ADDR, 16'h8005);
		rdchk(`BUCK6_CONTROL_ADDR, 16'hc005);
		check("cap", buck6_capacitor_setting, 2'b11);
		@(negedge clk);
		defaults_reload = 1'b1;
		@(negedge clk);
		defaults_reload = 1'b0;
		for (i = 0; i < 9; i++)
			rdchk(adr[i], rst[i]);
		i_host_model.wr(`BUCK4_SEQUENCING_ADDR, 16'h4480);
		i_host_model.wr(`BUCK6_SEQUENCING_ADDR, 16'h3c00);
		i_host_model.wr(`SWITCH_CONTROL_ADDR, 16'hbbd3);
		i_host_model.wr(`BUCK4_CONTROL_ADDR, 16'h0026);
		i_host_model.wr(`BUCK6_CONTROL_ADDR, 16'h040e);
		i_host_model.wr(`BUCK4_LOW_POWER_ADDR, 16'h710e);
		i_host_model.wr(`BUCK6_LOW_POWER_ADDR, 16'h1010);
		check("b4 dis", buck4_drive.discharge, 1'b1);
		check("b6 dis", buck6_drive.discharge, 1'b0);
		@(negedge clk);
		power_up_req = 1'b1;
		@(negedge clk);
		power_up_req = 1'b0;
		check("state", seq_state, SEQ_UP);
		check("slot", seq_slot, 4'h1);
		for (i = 1; i <= 14; i++)
		begin
			tick();
			check("b4 en", buck4_drive.enable, 1'b1);
			check("b6 en", buck6_drive.enable, i == 14);
			check("sw en", switch_enable, i == 14);
		end
		check("state", seq_state, SEQ_ACTIVE);
		check("b4 volt", buck4_drive.voltage, 7'h26);
		@(negedge clk);
		sw_hibernate = 1'b1;
		@(negedge clk);
		check("b4 en", buck4_drive.enable, 1'b1);
		check("b6 img", buck6_drive.voltage, 7'h10);
		check("sw en", switch_enable, 1'b1);
		low_power_input_one = 1'b1;
		@(negedge clk);
		check("b4 en", buck4_drive.enable, 1'b0);
		{sw_hibernate, low_power_input_one, gpio_hibernate} = 3'b001;
		@(negedge clk);
		check("b4 en", buck4_drive.enable, 1'b0);
		check("b6 img", buck6_drive.voltage, 7'h10);
		gpio_hibernate = 1'b0;
		@(negedge clk);
		check("b6 volt", buck6_drive.voltage, 7'h0e);
		i_host_model.wr(`BOOST5_CONTROL_ADDR, 16'h0003);
		check("ramp", boost5_drive.ramp, 2'b11);
		check("fb", boost5_drive.feedback, 2'b11);
		i_host_model.wr(`BOOST5_CONTROL_ADDR, 16'h0011);
		check("ramp", boost5_drive.ramp, 2'b10);
		check("fb", boost5_drive.feedback, 2'b01);
		fault = 4'h1;
		@(negedge clk);
		fault = 4'h0;
		check("irq", fault_irq, 1'b1);
		check("b4 en", buck4_drive.enable, 1'b0);
		check("sys", system_shutdown, 1'b0);
		fault = 4'h8;
		@(negedge clk);
		fault = 4'h0;
		check("sys", system_shutdown, 1'b1);
		check("state", seq_state, SEQ_DOWN);
		for (i = 1; i <= 14; i++)
		begin
			tick();
			check("b6 en", buck6_drive.enable, i < 14);
			check("sw en", switch_enable, i < 14);
		end
		check("state", seq_state, SEQ_OFF);
		check("b4 dis", buck4_drive.discharge, 1'b1);
		check("b6 dis", buck6_drive.discharge, 1'b0);
		// Second walk: boost joins at slot 1, a requested shutdown stops it at slot 3
		i_host_model.wr(`BOOST5_SEQUENCING_ADDR, 16'h44c0);
		i_host_model.wr(`BOOST5_CONTROL_ADDR, 16'h1202);
		i_host_model.wr(`BUCK6_LOW_POWER_ADDR, 16'h2200);
		check("ramp", boost5_drive.ramp, 2'b00);
		check("fb", boost5_drive.feedback, 2'b10);
		@(negedge clk);
		power_up_req = 1'b1;
		@(negedge clk);
		power_up_req = 1'b0;
		for (i = 1; i <= 14; i++)
		begin
			tick();
			check("b5 en", boost5_drive.enable, 1'b1);
		end
		check("state", seq_state, SEQ_ACTIVE);
		// Power-up request outside off is refused
		@(negedge clk);
		power_up_req = 1'b1;
		@(negedge clk);
		power_up_req = 1'b0;
		check("state", seq_state, SEQ_ACTIVE);
		low_power_input_two = 1'b1;
		@(negedge clk);
		check("b5 en", boost5_drive.enable, 1'b0);
		check("b6 sby", buck6_drive.standby, 1'b1);
		check("b6 ldo", buck6_drive.ldo_mode, 1'b0);
		i_host_model.wr(`BUCK6_LOW_POWER_ADDR, 16'h5210);
		check("b6 ldo", buck6_drive.ldo_mode, 1'b1);
		check("b6 sby", buck6_drive.standby, 1'b0);
		check("b6 img", buck6_drive.voltage, 7'h10);
		low_power_input_two = 1'b0;
		@(negedge clk);
		check("b5 en", boost5_drive.enable, 1'b1);
		check("b6 ldo", buck6_drive.ldo_mode, 1'b0);
		check("b6 volt", buck6_drive.voltage, 7'h0e);
		i_host_model.wr(`SWITCH_CONTROL_ADDR, 16'h7bd3);
		check("sw en", switch_enable, 1'b1);
		fault = 4'h8;
		@(negedge clk);
		fault = 4'h0;
		check("sw en", switch_enable, 1'b0);
		check("sys", system_shutdown, 1'b0);
		check("state", seq_state, SEQ_ACTIVE);
		@(negedge clk);
		check("irq", fault_irq, 1'b0);
		@(negedge clk);
		power_down_req = 1'b1;
		@(negedge clk);
		power_down_req = 1'b0;
		check("state", seq_state, SEQ_DOWN);
		check("slot", seq_slot, 4'h1);
		for (i = 1; i <= 14; i++)
		begin
			tick();
			check("b5 en", boost5_drive.enable, i < 3);
		end
		check("state", seq_state, SEQ_OFF);
		check("slot", seq_slot, 4'h0);
		close_out();
	end
endmodule
